// File: logic/timer01_pkg.sv
// Constants and types for the dual legacy counter/timer
// Functional notes
// - In event mode the count steps once per falling edge of the event pin.
// - Five clock sources: prescaled clock picks, or the system clock.
// - 13-bit mode: high byte holds upper eight, low byte bits 4..0 lower five.
// - 13-bit wrap from all ones sets the overflow flag and interrupt if enabled.
// - Timer mode: system clock when clock select is one, else prescaled clock.
// - Counting needs run bit and either no gating or active gating input.
// - Setting run does not clear the count.
// - Timer 1 mirrors timer 0 with its own bits and second gating input.
// - 16-bit mode counts all sixteen bits, enabled like 13-bit mode.
// - 8-bit reload: low byte wraps, sets flag, reloads from unchanged high byte.
// - Split mode: timer 0 low byte is an 8-bit counter with timer 0 controls.
// - Split mode: timer 0 high byte times only, runs on run 1, sets flag 1.
// - While split, timer 1 has no external clock and sets no flag, overflow still out.
// - While split, timer 1 runs unless its own mode is split.
// - External flags: edge mode latch and clear; level mode follow active input.
// - Mode field: 00 13-bit, 01 16-bit, 10 8-bit reload, 11 split or off.
// - Prescale: system clock /12, /4, /48, or external clock /8 synchronised.
// - Clock select is ignored while the counter select bit is one, except by timer 1 in split mode.
package timer01_pkg;
  localparam logic [7:0] ADDR_CTL = 8'h88;
  localparam logic [7:0] ADDR_MODE = 8'h89;
  localparam logic [7:0] ADDR_CL0 = 8'h8a;
  localparam logic [7:0] ADDR_CL1 = 8'h8b;
  localparam logic [7:0] ADDR_CH0 = 8'h8c;
  localparam logic [7:0] ADDR_CH1 = 8'h8d;
  localparam logic [7:0] ADDR_CLKSEL = 8'h8e;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int CTL_TF1 = 7;
  localparam int CTL_TR1 = 6;
  localparam int CTL_TF0 = 5;
  localparam int CTL_TR0 = 4;
  localparam int CTL_IE1 = 3;
  localparam int CTL_IT1 = 2;
  localparam int CTL_IE0 = 1;
  localparam int CTL_IT0 = 0;
  localparam int MODE_EXT_GATE_SEL_1 = 7;
  localparam int MODE_CT1 = 6;
  localparam int MODE_M1_LO = 4;
  localparam int MODE_EXT_GATE_SEL_0 = 3;
  localparam int MODE_CT0 = 2;
  localparam int MODE_M0_LO = 0;
  localparam int CKS_T1M = 3;
  localparam int CKS_T0M = 2;
  localparam int CKS_SCA_LO = 0;
  localparam logic [5:0] DIV_SYS12 = 6'h0c;
  localparam logic [5:0] DIV_SYS4 = 6'h04;
  localparam logic [5:0] DIV_SYS48 = 6'h30;
  localparam logic [2:0] EXT_DIV8_LAST = 3'h7;
  typedef enum logic [1:0] {
    MODE_13BIT = 2'b00,
    MODE_16BIT = 2'b01,
    MODE_8RELOAD = 2'b10,
    MODE_SPLIT = 2'b11
  } tmode_t;
  typedef enum logic [1:0] {
    SCALE_DIV12 = 2'b00,
    SCALE_DIV4 = 2'b01,
    SCALE_DIV48 = 2'b10,
    SCALE_EXT8 = 2'b11
  } scale_t;
  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } count_t;
  typedef struct packed {
    count_t cnt;
    logic ovf;
  } step_t;
endpackage

// File: logic/pin_sync.sv
// Two-stage synchroniser with edge detection for pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 5
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] meta;
  logic [W-1:0] prev;
  // First stage is read only by the second
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      meta <= '0;
      level <= '0;
      prev <= '0;
    end else begin
      meta <= d;
      level <= meta;
      prev <= level;
    end
  end
  assign fall = prev & ~level;
  assign rise = ~prev & level;
endmodule

// File: logic/timer01.sv
// Dual legacy counter/timer with its control, mode and clock select registers
`timescale 1ns/1ps
module timer01 (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  input wire logic event_pin_0,
  input wire logic event_pin_1,
  input wire logic gating_input_0,
  input wire logic gating_input_1,
  input wire logic ext_clk,
  input wire logic ext_irq_polarity_0,
  input wire logic ext_irq_polarity_1,
  input wire logic timer_irq_enable_0,
  input wire logic timer_irq_enable_1,
  input wire logic vec_ack_timer_0,
  input wire logic vec_ack_timer_1,
  input wire logic vec_ack_ext_0,
  input wire logic vec_ack_ext_1,
  output logic timer_irq_0,
  output logic timer_irq_1,
  output logic ext_irq_req_0,
  output logic ext_irq_req_1,
  output logic t1_overflow
);
  logic [7:0] ctl, next_ctl;
  logic [7:0] mode_reg, next_mode_reg;
  logic [7:0] clksel, next_clksel;
  timer01_pkg::count_t c0, next_c0, c1, next_c1;
  logic [5:0] pre_cnt, next_pre_cnt;
  logic [2:0] ext_cnt, next_ext_cnt;
  logic [7:0] next_sfr_rdata;
  logic next_t1_overflow;
  logic [4:0] lvl, rise, fall;
  logic act0, act1, edge0, edge1, pre_tick, split;
  logic src0, src1, tick0, tick1, tick_h, ovf0, ovf1, ovf_h;
  logic [5:0] div;
  timer01_pkg::tmode_t m0, m1;
  timer01_pkg::step_t s0, s1;

  // Bits 0/1 event pins, 2/3 gating inputs, 4 external clock
  pin_sync #(.W(5)) u_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .d({ext_clk, gating_input_1, gating_input_0, event_pin_1, event_pin_0}),
    .level(lvl),
    .rise(rise),
    .fall(fall)
  );

  // One count step for the non-split modes
  function automatic timer01_pkg::step_t count_step(input timer01_pkg::tmode_t m, input timer01_pkg::count_t c);
    timer01_pkg::step_t r;
    r.cnt = c;
    r.ovf = 1'b0;
    case (m)
      timer01_pkg::MODE_13BIT: begin
        // Bits 7..5 of the low byte are left alone
        r.cnt.lo[4:0] = c.lo[4:0] + 5'h01;
        if (&c.lo[4:0]) begin
          r.cnt.hi = c.hi + 8'h01;
        end
        r.ovf = (&c.hi) & (&c.lo[4:0]);
      end
      timer01_pkg::MODE_16BIT: begin
        r.cnt = c + 16'h0001;
        r.ovf = &c;
      end
      timer01_pkg::MODE_8RELOAD: begin
        if (&c.lo) begin
          r.cnt.lo = c.hi;
          r.ovf = 1'b1;
        end else begin
          r.cnt.lo = c.lo + 8'h01;
        end
      end
      default: begin
        r.cnt = c;
      end
    endcase
    return r;
  endfunction

  always_comb begin
    m0 = timer01_pkg::tmode_t'(mode_reg[timer01_pkg::MODE_M0_LO +: 2]);
    m1 = timer01_pkg::tmode_t'(mode_reg[timer01_pkg::MODE_M1_LO +: 2]);
    split = (m0 == timer01_pkg::MODE_SPLIT);
    // Gating input is active low unless its polarity bit is one
    act0 = ext_irq_polarity_0 ? lvl[2] : ~lvl[2];
    act1 = ext_irq_polarity_1 ? lvl[3] : ~lvl[3];
    edge0 = ext_irq_polarity_0 ? rise[2] : fall[2];
    edge1 = ext_irq_polarity_1 ? rise[3] : fall[3];

    // Prescaler
    case (timer01_pkg::scale_t'(clksel[timer01_pkg::CKS_SCA_LO +: 2]))
      timer01_pkg::SCALE_DIV4: div = timer01_pkg::DIV_SYS4;
      timer01_pkg::SCALE_DIV48: div = timer01_pkg::DIV_SYS48;
      default: div = timer01_pkg::DIV_SYS12;
    endcase
    next_pre_cnt = pre_cnt;
    next_ext_cnt = ext_cnt;
    if (timer01_pkg::scale_t'(clksel[timer01_pkg::CKS_SCA_LO +: 2]) == timer01_pkg::SCALE_EXT8) begin
      // External clock is only ever seen through the synchroniser
      pre_tick = fall[4] && (ext_cnt == timer01_pkg::EXT_DIV8_LAST);
      if (fall[4]) begin
        next_ext_cnt = ext_cnt + 3'h1;
      end
    end else begin
      // >= recovers cleanly when the divisor shrinks mid-count
      pre_tick = (pre_cnt >= div - 6'h01);
      next_pre_cnt = pre_tick ? 6'h00 : pre_cnt + 6'h01;
    end

    // Timer 0 source and enable
    if (mode_reg[timer01_pkg::MODE_CT0]) begin
      src0 = fall[0];
    end else begin
      src0 = clksel[timer01_pkg::CKS_T0M] ? 1'b1 : pre_tick;
    end
    tick0 = ctl[timer01_pkg::CTL_TR0] & (~mode_reg[timer01_pkg::MODE_EXT_GATE_SEL_0] | act0) & src0;

    // Timer 1 source and enable
    if (split) begin
      src1 = clksel[timer01_pkg::CKS_T1M] ? 1'b1 : pre_tick;
      tick1 = (m1 != timer01_pkg::MODE_SPLIT) & src1;
    end else begin
      if (mode_reg[timer01_pkg::MODE_CT1]) begin
        src1 = fall[1];
      end else begin
        src1 = clksel[timer01_pkg::CKS_T1M] ? 1'b1 : pre_tick;
      end
      tick1 = ctl[timer01_pkg::CTL_TR1] & (~mode_reg[timer01_pkg::MODE_EXT_GATE_SEL_1] | act1) & src1;
    end

    // Count registers; run does not touch the count
    next_c0 = c0;
    next_c1 = c1;
    s0 = count_step(m0, c0);
    s1 = count_step(m1, c1);
    ovf0 = 1'b0;
    ovf_h = 1'b0;
    tick_h = 1'b0;
    if (split) begin
      if (tick0) begin
        next_c0.lo = c0.lo + 8'h01;
        ovf0 = &c0.lo;
      end
      // High half times only, from the timer 1 clock select
      tick_h = ctl[timer01_pkg::CTL_TR1] & (clksel[timer01_pkg::CKS_T1M] | pre_tick);
      if (tick_h) begin
        next_c0.hi = c0.hi + 8'h01;
        ovf_h = &c0.hi;
      end
    end else if (tick0) begin
      next_c0 = s0.cnt;
      ovf0 = s0.ovf;
    end
    ovf1 = tick1 & s1.ovf;
    if (tick1) begin
      next_c1 = s1.cnt;
    end
    next_t1_overflow = ovf1;

    // Software writes win over a same-cycle count step
    next_mode_reg = mode_reg;
    next_clksel = clksel;
    next_ctl = ctl;
    if (sfr_wr) begin
      case (sfr_addr)
        timer01_pkg::ADDR_CTL: next_ctl = sfr_wdata;
        timer01_pkg::ADDR_MODE: next_mode_reg = sfr_wdata;
        timer01_pkg::ADDR_CLKSEL: next_clksel = sfr_wdata;
        timer01_pkg::ADDR_CL0: next_c0.lo = sfr_wdata;
        timer01_pkg::ADDR_CH0: next_c0.hi = sfr_wdata;
        timer01_pkg::ADDR_CL1: next_c1.lo = sfr_wdata;
        timer01_pkg::ADDR_CH1: next_c1.hi = sfr_wdata;
        default: next_ctl = ctl;
      endcase
    end
    // Clears first, sets last so a same-cycle event is kept
    if (vec_ack_timer_0) begin
      next_ctl[timer01_pkg::CTL_TF0] = 1'b0;
    end
    if (vec_ack_timer_1) begin
      next_ctl[timer01_pkg::CTL_TF1] = 1'b0;
    end
    if (vec_ack_ext_0) begin
      next_ctl[timer01_pkg::CTL_IE0] = 1'b0;
    end
    if (vec_ack_ext_1) begin
      next_ctl[timer01_pkg::CTL_IE1] = 1'b0;
    end
    if (ovf0) begin
      next_ctl[timer01_pkg::CTL_TF0] = 1'b1;
    end
    if (split ? ovf_h : ovf1) begin
      next_ctl[timer01_pkg::CTL_TF1] = 1'b1;
    end
    // Stored flag only matters in edge mode; level mode is read live
    if (!next_ctl[timer01_pkg::CTL_IT0]) begin
      next_ctl[timer01_pkg::CTL_IE0] = 1'b0;
    end else if (edge0) begin
      next_ctl[timer01_pkg::CTL_IE0] = 1'b1;
    end
    if (!next_ctl[timer01_pkg::CTL_IT1]) begin
      next_ctl[timer01_pkg::CTL_IE1] = 1'b0;
    end else if (edge1) begin
      next_ctl[timer01_pkg::CTL_IE1] = 1'b1;
    end

    // Registered read data, one cycle after the read strobe
    next_sfr_rdata = sfr_rdata;
    if (sfr_rd) begin
      case (sfr_addr)
        timer01_pkg::ADDR_CTL: next_sfr_rdata = {ctl[7:4], ext_irq_req_1, ctl[2], ext_irq_req_0, ctl[0]};
        timer01_pkg::ADDR_MODE: next_sfr_rdata = mode_reg;
        timer01_pkg::ADDR_CLKSEL: next_sfr_rdata = clksel;
        timer01_pkg::ADDR_CL0: next_sfr_rdata = c0.lo;
        timer01_pkg::ADDR_CH0: next_sfr_rdata = c0.hi;
        timer01_pkg::ADDR_CL1: next_sfr_rdata = c1.lo;
        timer01_pkg::ADDR_CH1: next_sfr_rdata = c1.hi;
        default: next_sfr_rdata = timer01_pkg::RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctl <= timer01_pkg::RESET_BYTE;
      mode_reg <= timer01_pkg::RESET_BYTE;
      clksel <= timer01_pkg::RESET_BYTE;
      c0 <= '0;
      c1 <= '0;
      pre_cnt <= 6'h00;
      ext_cnt <= 3'h0;
      sfr_rdata <= timer01_pkg::RESET_BYTE;
      t1_overflow <= 1'b0;
    end else begin
      ctl <= next_ctl;
      mode_reg <= next_mode_reg;
      clksel <= next_clksel;
      c0 <= next_c0;
      c1 <= next_c1;
      pre_cnt <= next_pre_cnt;
      ext_cnt <= next_ext_cnt;
      sfr_rdata <= next_sfr_rdata;
      t1_overflow <= next_t1_overflow;
    end
  end

  assign timer_irq_0 = ctl[timer01_pkg::CTL_TF0] & timer_irq_enable_0;
  assign timer_irq_1 = ctl[timer01_pkg::CTL_TF1] & timer_irq_enable_1;
  assign ext_irq_req_0 = ctl[timer01_pkg::CTL_IT0] ? ctl[timer01_pkg::CTL_IE0] : act0;
  assign ext_irq_req_1 = ctl[timer01_pkg::CTL_IT1] ? ctl[timer01_pkg::CTL_IE1] : act1;
endmodule

// File: verif/timer01_monitor.sv
// Port-level assertions for the dual counter/timer
`timescale 1ns/1ps
module timer01_monitor (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic timer_irq_enable_0,
  input wire logic timer_irq_enable_1,
  input wire logic timer_irq_0,
  input wire logic timer_irq_1,
  input wire logic t1_overflow
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  AST_IRQ_EN0: assert property (!timer_irq_enable_0 |-> !timer_irq_0)
    else $error("timer 0 interrupt without enable");
  AST_IRQ_EN1: assert property (!timer_irq_enable_1 |-> !timer_irq_1)
    else $error("timer 1 interrupt without enable");
  AST_UNMAPPED: assert property (sfr_rd && (sfr_addr < 8'h88 || sfr_addr > 8'h8e) |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_MODE_RB: assert property ((sfr_wr && sfr_addr == 8'h89) ##1 (sfr_rd && !sfr_wr && sfr_addr == 8'h89)
    |=> sfr_rdata == $past(sfr_wdata, 2))
    else $error("mode register readback wrong");
  AST_CKS_RB: assert property ((sfr_wr && sfr_addr == 8'h8e) ##1 (sfr_rd && !sfr_wr && sfr_addr == 8'h8e)
    |=> sfr_rdata == $past(sfr_wdata, 2))
    else $error("clock select readback wrong");
  AST_T1OVF_PULSE: assert property (t1_overflow |=> !t1_overflow)
    else $error("timer 1 overflow pulse too long");
  AST_RESET_RDATA: assert property ($rose(rstn) |-> sfr_rdata == 8'h00)
    else $error("read data not clear after reset");
  AST_RD_HOLD: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved without a read");
  cover property (t1_overflow);
  cover property ($rose(timer_irq_0));
  cover property ($rose(timer_irq_1));
endmodule

bind timer01 timer01_monitor mon (.clk_sys, .rstn, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rdata,
  .timer_irq_enable_0, .timer_irq_enable_1, .timer_irq_0, .timer_irq_1, .t1_overflow);

// File: verif/event_src.sv
// Event pin source giving a burst of falling edges
`timescale 1ns/1ps
module event_src (
  input wire logic clk_sys,
  input wire logic go,
  input wire logic [3:0] pulses,
  output logic pin
);
  initial pin = 1'b1;
  // Three clocks a level leaves margin over the sampling minimum
  always @(posedge go) begin
    repeat (pulses) begin
      repeat (3) @(negedge clk_sys);
      pin = 1'b0;
      repeat (3) @(negedge clk_sys);
      pin = 1'b1;
    end
  end
endmodule

// File: verif/timer01_tb.sv
// Self-checking bench for the dual counter/timer
`timescale 1ns/1ps
module timer01_tb;
  logic clk_sys, rstn, sfr_wr, sfr_rd, event_pin_0, event_pin_1, gating_input_0, gating_input_1, ext_clk, go;
  logic ext_irq_polarity_0, ext_irq_polarity_1, timer_irq_enable_0, timer_irq_enable_1;
  logic vec_ack_timer_0, vec_ack_timer_1, vec_ack_ext_0, vec_ack_ext_1;
  logic timer_irq_0, timer_irq_1, ext_irq_req_0, ext_irq_req_1, t1_overflow;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, v;
  int bad_count = 0;
  int checked = 0;
  timer01 dut (.clk_sys, .rstn, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rdata, .event_pin_0, .event_pin_1,
    .gating_input_0, .gating_input_1, .ext_clk, .ext_irq_polarity_0, .ext_irq_polarity_1, .timer_irq_enable_0,
    .timer_irq_enable_1, .vec_ack_timer_0, .vec_ack_timer_1, .vec_ack_ext_0, .vec_ack_ext_1, .timer_irq_0,
    .timer_irq_1, .ext_irq_req_0, .ext_irq_req_1, .t1_overflow);
  event_src src (.clk_sys, .go, .pulses(4'h5), .pin(event_pin_0));
  assign event_pin_1 = event_pin_0;
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Idle cycle after each access so the next call never re-raises a strobe in the same step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk_sys);
    sfr_wr = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk_sys);
    sfr_rd = 1'b0;
    v = sfr_rdata;
    @(negedge clk_sys);
  endtask
  // Write, then read back in the very next cycle
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk_sys);
    sfr_wr = 1'b0;
    sfr_rd = 1'b1;
    @(negedge clk_sys);
    sfr_rd = 1'b0;
    v = sfr_rdata;
    @(negedge clk_sys);
  endtask
  // Two writes: a flag set racing the first write survives it
  task automatic stop();
    wr(8'h88, 8'h00);
    wr(8'h88, 8'h00);
  endtask
  task automatic wait_hi(input int w, input int n);
    for (int i = 0; i < n && !(w ? timer_irq_1 : timer_irq_0); i++) @(negedge clk_sys);
  endtask
  task automatic ack(input bit w);
    vec_ack_timer_0 = !w;
    vec_ack_timer_1 = w;
    @(negedge clk_sys);
    vec_ack_timer_0 = 1'b0;
    vec_ack_timer_1 = 1'b0;
    chk({6'h0, timer_irq_1, timer_irq_0}, 8'h00);
  endtask
  task automatic t_reset();
    for (int a = 8'h88; a <= 8'h8e; a++) begin
      rd(a[7:0]);
      chk(v, timer01_pkg::RESET_BYTE);
    end
    rd(8'h80);
    chk(v, 8'h00);
    wr_rd(8'h8e, 8'hf4);
    chk(v, 8'hf4);
    wr_rd(8'h89, 8'h5a);
    chk(v, 8'h5a);
    $display("test reset done");
  endtask
  task automatic t_ovf(input logic [7:0] m, input logic [7:0] ch, input logic [7:0] cl, input logic [7:0] ech);
    stop();
    wr(8'h8e, 8'h04);
    wr(8'h8c, ch);
    wr(8'h8a, cl);
    wr(8'h89, m);
    wr(8'h88, 8'h10);
    wait_hi(0, 20);
    chk({7'h0, timer_irq_0}, 8'h01);
    rd(8'h88);
    chk(v, 8'h30);
    timer_irq_enable_0 = 1'b0;
    @(negedge clk_sys);
    chk({7'h0, timer_irq_0}, 8'h00);
    timer_irq_enable_0 = 1'b1;
    ack(1'b0);
    stop();
    rd(8'h8c);
    chk(v, ech);
    $display("test overflow mode %h done", m);
  endtask
  task automatic t_scale();
    int n;
    int div [3] = '{12, 4, 48};
    for (int s = 0; s < 3; s++) begin
      stop();
      wr(8'h8e, s[7:0]);
      wr(8'h8c, 8'hfe);
      wr(8'h8a, 8'hfe);
      wr(8'h89, 8'h02);
      wr(8'h88, 8'h10);
      wait_hi(0, 200);
      vec_ack_timer_0 = 1'b1;
      n = 0;
      do begin
        @(negedge clk_sys);
        vec_ack_timer_0 = 1'b0;
        n++;
      end while (!timer_irq_0 && n < 200);
      chk(n[7:0], 8'(2 * div[s]));
    end
    // External clock divided by eight: two ticks take the reload timer from 0xfe to overflow
    stop();
    wr(8'h8e, 8'h03);
    wr(8'h8c, 8'hfe);
    wr(8'h8a, 8'hfe);
    wr(8'h89, 8'h02);
    wr(8'h88, 8'h10);
    for (int i = 1; i <= 16; i++) begin
      repeat (3) @(negedge clk_sys);
      ext_clk = 1'b1;
      repeat (3) @(negedge clk_sys);
      ext_clk = 1'b0;
      if (i == 15) begin
        chk({7'h0, timer_irq_0}, 8'h00);
      end
    end
    repeat (4) @(negedge clk_sys);
    chk({7'h0, timer_irq_0}, 8'h01);
    $display("test prescale done");
  endtask
  task automatic t_event();
    stop();
    wr(8'h8e, 8'h0c);
    wr(8'h8a, 8'h00);
    wr(8'h89, 8'h55);
    wr(8'h88, 8'h50);
    go = 1'b1;
    repeat (40) @(negedge clk_sys);
    go = 1'b0;
    rd(8'h8a);
    chk(v, 8'h05);
    rd(8'h8b);
    chk(v, 8'h05);
    $display("test event done");
  endtask
  task automatic t_gate();
    stop();
    wr(8'h8e, 8'h04);
    wr(8'h8a, 8'h00);
    wr(8'h89, 8'h09);
    wr(8'h88, 8'h10);
    repeat (10) @(negedge clk_sys);
    chk({6'h0, ext_irq_req_1, ext_irq_req_0}, 8'h00);
    rd(8'h8a);
    chk(v, 8'h00);
    gating_input_0 = 1'b0;
    gating_input_1 = 1'b0;
    repeat (10) @(negedge clk_sys);
    chk({6'h0, ext_irq_req_1, ext_irq_req_0}, 8'h03);
    rd(8'h8a);
    chk({7'h0, v == 8'h00}, 8'h00);
    gating_input_1 = 1'b1;
    wr(8'h88, 8'h01);
    gating_input_0 = 1'b1;
    repeat (5) @(negedge clk_sys);
    gating_input_0 = 1'b0;
    repeat (5) @(negedge clk_sys);
    gating_input_0 = 1'b1;
    repeat (5) @(negedge clk_sys);
    chk({7'h0, ext_irq_req_0}, 8'h01);
    wr(8'h88, 8'h01);
    chk({7'h0, ext_irq_req_0}, 8'h00);
    gating_input_0 = 1'b0;
    repeat (5) @(negedge clk_sys);
    gating_input_0 = 1'b1;
    repeat (5) @(negedge clk_sys);
    chk({7'h0, ext_irq_req_0}, 8'h01);
    vec_ack_ext_0 = 1'b1;
    @(negedge clk_sys);
    vec_ack_ext_0 = 1'b0;
    chk({7'h0, ext_irq_req_0}, 8'h00);
    wr(8'h88, 8'h00);
    ext_irq_polarity_0 = 1'b1;
    repeat (5) @(negedge clk_sys);
    chk({7'h0, ext_irq_req_0}, 8'h01);
    ext_irq_polarity_0 = 1'b0;
    $display("test gate done");
  endtask
  task automatic t_split();
    logic [7:0] v0;
    stop();
    wr(8'h8e, 8'h08);
    wr(8'h8c, 8'h00);
    wr(8'h8a, 8'h33);
    wr(8'h8d, 8'hf0);
    wr(8'h8b, 8'hf0);
    wr(8'h89, 8'h23);
    wr(8'h88, 8'h40);
    repeat (40) @(negedge clk_sys);
    rd(8'h88);
    chk(v, 8'h40);
    wait_hi(1, 300);
    chk({7'h0, timer_irq_1}, 8'h01);
    timer_irq_enable_1 = 1'b0;
    @(negedge clk_sys);
    chk({7'h0, timer_irq_1}, 8'h00);
    timer_irq_enable_1 = 1'b1;
    ack(1'b1);
    rd(8'h8a);
    chk(v, 8'h33);
    wr(8'h89, 8'h33);
    rd(8'h8b);
    v0 = v;
    repeat (20) @(negedge clk_sys);
    rd(8'h8b);
    chk(v, v0);
    $display("test split done");
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    {rstn, sfr_wr, sfr_rd, go, ext_clk, ext_irq_polarity_0, ext_irq_polarity_1} = 7'h00;
    {vec_ack_timer_0, vec_ack_timer_1, vec_ack_ext_0, vec_ack_ext_1} = 4'h0;
    {gating_input_0, gating_input_1, timer_irq_enable_0, timer_irq_enable_1} = 4'hf;
    {sfr_addr, sfr_wdata} = 16'h0000;
    repeat (16) @(negedge clk_sys);
    rstn = 1'b1;
    // Synchroniser comes out of reset low; let the idle gating level reach it first
    repeat (2) @(negedge clk_sys);
    t_reset();
    t_ovf(8'h00, 8'hff, 8'hff, 8'h00);
    t_ovf(8'h01, 8'hff, 8'hfe, 8'h00);
    t_ovf(8'h02, 8'h80, 8'hfe, 8'h80);
    t_scale();
    t_event();
    t_gate();
    t_split();
    print_verdict();
  end
  initial begin
    #100000;
    bad_count++;
    print_verdict();
  end
endmodule
